// ---- pgb_pkg.sv ----
// constants and carriers for the power-good / buck-one configuration bank
// assumes a single 25 MHz register-domain clock
package pgb_pkg;

   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

   // register offsets
   localparam logic [7:0] OFS_UNLOCK = 8'h0b;
   localparam logic [7:0] OFS_GOOD_STATUS = 8'h0c;
   localparam logic [7:0] OFS_PG_CTRL = 8'h0d;
   localparam logic [7:0] OFS_BUCK1_CTRL = 8'h0e;

   // reset values and the unlock key
   localparam logic [7:0] RST_UNLOCK = 8'h00;
   localparam logic [7:0] RST_PG_CTRL = 8'h0c;
   localparam logic [7:0] RST_BUCK1_CTRL = 8'h18;
   localparam logic [7:0] UNLOCK_KEY = 8'h7d;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // field positions
   localparam int FLD_MASK1 = 3;
   localparam int FLD_MASK2 = 2;
   localparam int FLD_DLY_HI = 1;
   localparam int FLD_EXT = 7;
   localparam int FLD_CODE_HI = 5;
   localparam int FLD_CODE_FIXED = 0;

   // delay codes
   localparam logic [1:0] DLY_SEL_0 = 2'h0;
   localparam logic [1:0] DLY_SEL_1 = 2'h1;
   localparam logic [1:0] DLY_SEL_2 = 2'h2;

   // power-good release delays
   localparam int unsigned DLY0_MS = 20;
   localparam int unsigned DLY1_MS = 100;
   localparam int unsigned DLY2_MS = 200;
   localparam int unsigned DLY3_MS = 400;
   localparam int unsigned DLY0_CYC = DLY0_MS * CLK_KHZ;
   localparam int unsigned DLY1_CYC = DLY1_MS * CLK_KHZ;
   localparam int unsigned DLY2_CYC = DLY2_MS * CLK_KHZ;
   localparam int unsigned DLY3_CYC = DLY3_MS * CLK_KHZ;

   // buck voltage map in millivolts
   localparam logic [5:0] CODE_SEG1 = 6'h18;
   localparam logic [5:0] CODE_SEG2 = 6'h35;
   localparam logic [5:0] CODE_SEG3 = 6'h38;
   localparam logic [11:0] MV_BASE0 = 12'h384;
   localparam logic [11:0] MV_BASE1 = 12'h5dc;
   localparam logic [11:0] MV_BASE2 = 12'hbb8;
   localparam logic [11:0] MV_TOP = 12'hce4;
   localparam logic [11:0] MV_STEP0 = 12'h019;
   localparam logic [11:0] MV_STEP1 = 12'h032;
   localparam logic [11:0] MV_STEP2 = 12'h064;

   typedef struct packed {
      logic first_linear_good_mask;
      logic second_linear_good_mask;
      logic [1:0] good_output_delay;
   } pgb_pg_ctrl_t;

   typedef struct packed {
      logic buck_one_external_adjust;
      logic [5:0] buck_one_voltage_code;
   } pgb_buck_ctrl_t;

endpackage

// ---- pgb_delay_timer.sv ----
// power-good release timer: counts good time against the selected delay
// assumes rails_good is already synchronous to clk
module pgb_delay_timer #(
   parameter int W = 24,
   parameter int unsigned CYC0 = pgb_pkg::DLY0_CYC,
   parameter int unsigned CYC1 = pgb_pkg::DLY1_CYC,
   parameter int unsigned CYC2 = pgb_pkg::DLY2_CYC,
   parameter int unsigned CYC3 = pgb_pkg::DLY3_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic rails_good,
   input wire logic [1:0] sel,
   output logic released_r
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] limit;

   initial
   begin
      if (W < 2 || W > 31 || CYC3 >= (32'h1 << W) || CYC0 == 0 || CYC1 == 0 || CYC2 == 0)
         $error("pgb_delay_timer: delay counts do not fit the counter");
   end

   always_comb
   begin
      case (sel)
         pgb_pkg::DLY_SEL_0: limit = W'(CYC0);
         pgb_pkg::DLY_SEL_1: limit = W'(CYC1);
         pgb_pkg::DLY_SEL_2: limit = W'(CYC2);
         default: limit = W'(CYC3);
      endcase
   end

   // counter saturates at the limit; any drop restarts the whole delay
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cnt_r <= '0;
      else if (!rails_good)
         cnt_r <= '0;
      else if (cnt_r < limit)
         cnt_r <= cnt_r + W'(1);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         released_r <= 1'b0;
      else
         released_r <= rails_good && (cnt_r >= limit);
   end

endmodule

// ---- pgb_config_bank.sv ----
// power-good control and buck-one control registers with unlock protection
// assumes the serial port decodes transactions into one-cycle rd/wr strobes
module pgb_config_bank #(
   parameter int unsigned DLY0_CYC = pgb_pkg::DLY0_CYC,
   parameter int unsigned DLY1_CYC = pgb_pkg::DLY1_CYC,
   parameter int unsigned DLY2_CYC = pgb_pkg::DLY2_CYC,
   parameter int unsigned DLY3_CYC = pgb_pkg::DLY3_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_r,
   input wire logic first_linear_good_status,
   input wire logic second_linear_good_status,
   output logic power_good_output_o_r,
   output logic power_good_output_oe_r,
   output logic buck_one_external_adjust_r,
   output logic [5:0] buck_one_voltage_code_r,
   output logic [11:0] buck_one_target_mv_r,
   output logic write_refused_r
);

   pgb_pkg::pgb_pg_ctrl_t pg_ctrl_r;
   pgb_pkg::pgb_buck_ctrl_t buck_ctrl_r;
   logic [7:0] unlock_code_r;
   logic unlocked;
   logic prot_hit;
   logic rails_good;
   logic released;
   logic [11:0] target_nxt;
   logic [7:0] rdata_nxt;
   logic [5:0] code_nxt;

   initial
   begin
      if (DLY0_CYC == 0 || DLY0_CYC > DLY1_CYC || DLY1_CYC > DLY2_CYC || DLY2_CYC > DLY3_CYC)
         $error("pgb_config_bank: delay counts must be nonzero and ascending");
   end

   assign unlocked = (unlock_code_r == pgb_pkg::UNLOCK_KEY);
   assign prot_hit = (reg_addr == pgb_pkg::OFS_PG_CTRL) || (reg_addr == pgb_pkg::OFS_BUCK1_CTRL);

   // unlock register: any write other than to itself consumes it
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         unlock_code_r <= pgb_pkg::RST_UNLOCK;
      else if (reg_wr && reg_addr == pgb_pkg::OFS_UNLOCK)
         unlock_code_r <= reg_wdata;
      else if (reg_wr)
         unlock_code_r <= pgb_pkg::RST_UNLOCK;
   end

   // power-good control; only the low nibble exists, so upper bits cannot be stored
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         pg_ctrl_r <= pgb_pkg::RST_PG_CTRL[3:0];
      else if (reg_wr && reg_addr == pgb_pkg::OFS_PG_CTRL && unlocked)
      begin
         pg_ctrl_r.first_linear_good_mask <= reg_wdata[pgb_pkg::FLD_MASK1];
         pg_ctrl_r.second_linear_good_mask <= reg_wdata[pgb_pkg::FLD_MASK2];
         pg_ctrl_r.good_output_delay <= reg_wdata[pgb_pkg::FLD_DLY_HI:0];
      end
   end

   // buck-one control; bit 6 has no storage and the code lsb is kept
   assign code_nxt = {reg_wdata[pgb_pkg::FLD_CODE_HI:1], buck_ctrl_r.buck_one_voltage_code[pgb_pkg::FLD_CODE_FIXED]};

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         buck_ctrl_r.buck_one_external_adjust <= pgb_pkg::RST_BUCK1_CTRL[pgb_pkg::FLD_EXT];
         buck_ctrl_r.buck_one_voltage_code <= pgb_pkg::RST_BUCK1_CTRL[pgb_pkg::FLD_CODE_HI:0];
      end
      else if (reg_wr && reg_addr == pgb_pkg::OFS_BUCK1_CTRL && unlocked)
      begin
         buck_ctrl_r.buck_one_external_adjust <= reg_wdata[pgb_pkg::FLD_EXT];
         buck_ctrl_r.buck_one_voltage_code <= code_nxt;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         write_refused_r <= 1'b0;
      else
         write_refused_r <= reg_wr && prot_hit && !unlocked;
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_nxt = pgb_pkg::READ_ZERO;
      case (reg_addr)
         pgb_pkg::OFS_UNLOCK: rdata_nxt = unlock_code_r;
         pgb_pkg::OFS_GOOD_STATUS: rdata_nxt = {6'h00, first_linear_good_status, second_linear_good_status};
         pgb_pkg::OFS_PG_CTRL: rdata_nxt = {4'h0, pg_ctrl_r};
         pgb_pkg::OFS_BUCK1_CTRL: rdata_nxt = {buck_ctrl_r.buck_one_external_adjust, 1'b0,
                                               buck_ctrl_r.buck_one_voltage_code};
         default: rdata_nxt = pgb_pkg::READ_ZERO;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         reg_rdata_r <= pgb_pkg::READ_ZERO;
      else if (reg_rd)
         reg_rdata_r <= rdata_nxt;
   end

   // voltage map; zero target means the code is not in charge
   always_comb
   begin
      logic [5:0] c;
      c = buck_ctrl_r.buck_one_voltage_code;
      if (buck_ctrl_r.buck_one_external_adjust)
         target_nxt = 12'h000;
      else if (c < pgb_pkg::CODE_SEG1)
         target_nxt = pgb_pkg::MV_BASE0 + 12'(c) * pgb_pkg::MV_STEP0;
      else if (c < pgb_pkg::CODE_SEG2)
         target_nxt = pgb_pkg::MV_BASE1 + 12'(c - pgb_pkg::CODE_SEG1) * pgb_pkg::MV_STEP1;
      else if (c < pgb_pkg::CODE_SEG3)
         target_nxt = pgb_pkg::MV_BASE2 + 12'(c - pgb_pkg::CODE_SEG2) * pgb_pkg::MV_STEP2;
      else
         target_nxt = pgb_pkg::MV_TOP;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         buck_one_target_mv_r <= 12'h000;
         buck_one_external_adjust_r <= 1'b0;
         buck_one_voltage_code_r <= 6'h00;
      end
      else
      begin
         buck_one_target_mv_r <= target_nxt;
         buck_one_external_adjust_r <= buck_ctrl_r.buck_one_external_adjust;
         buck_one_voltage_code_r <= buck_ctrl_r.buck_one_voltage_code;
      end
   end

   // a masked rail counts as good
   assign rails_good = (first_linear_good_status || pg_ctrl_r.first_linear_good_mask)
                    && (second_linear_good_status || pg_ctrl_r.second_linear_good_mask);

   pgb_delay_timer #(
      .W(24),
      .CYC0(DLY0_CYC),
      .CYC1(DLY1_CYC),
      .CYC2(DLY2_CYC),
      .CYC3(DLY3_CYC)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .rails_good(rails_good),
      .sel(pg_ctrl_r.good_output_delay),
      .released_r(released)
   );

   // open drain: enable pulls low, pin value mirrors release
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         power_good_output_o_r <= 1'b0;
         power_good_output_oe_r <= 1'b1;
      end
      else
      begin
         power_good_output_o_r <= released;
         power_good_output_oe_r <= !released;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_unlock;
      reg_wr && reg_addr == pgb_pkg::OFS_UNLOCK && reg_wdata == pgb_pkg::UNLOCK_KEY;
   endsequence

   sequence s_prot_wr;
      reg_wr && prot_hit;
   endsequence

   a_locked_write_ignored: assert property (
      s_prot_wr and !unlocked |=> $stable(pg_ctrl_r) && $stable(buck_ctrl_r) && write_refused_r)
      else $error("protected write took effect while locked");

   a_unlock_one_shot: assert property (
      s_unlock ##1 s_prot_wr |=> !unlocked && !write_refused_r)
      else $error("unlock did not allow exactly one write");

   a_unlock_one_shot_second: assert property (
      s_unlock ##1 (reg_wr && reg_addr != pgb_pkg::OFS_UNLOCK) ##1 s_prot_wr |=> write_refused_r)
      else $error("unlock allowed a second write");

   a_pg_reserved_zero: assert property (
      reg_rd && reg_addr == pgb_pkg::OFS_PG_CTRL |=> reg_rdata_r[7:4] == 4'h0)
      else $error("reserved power-good bits read nonzero");

   a_buck_reserved_lsb: assert property (
      reg_rd && reg_addr == pgb_pkg::OFS_BUCK1_CTRL |=> !reg_rdata_r[6] && reg_rdata_r[0] == pgb_pkg::RST_BUCK1_CTRL[0])
      else $error("buck reserved bit or fixed lsb wrong");

   a_mask1_drop: assert property (
      !first_linear_good_status && !pg_ctrl_r.first_linear_good_mask |-> ##2 power_good_output_oe_r)
      else $error("unmasked first rail low did not pull pin low");

   a_mask2_drop: assert property (
      !second_linear_good_status && !pg_ctrl_r.second_linear_good_mask |-> ##2 power_good_output_oe_r)
      else $error("unmasked second rail low did not pull pin low");

   a_no_early_release: assert property (
      $fell(power_good_output_oe_r) |-> $past(rails_good, 2) && $past(released))
      else $error("pin released without the rails good");

   a_target_map: assert property (
      !buck_ctrl_r.buck_one_external_adjust && buck_ctrl_r.buck_one_voltage_code == 6'h10 |=> buck_one_target_mv_r == 12'h514)
      else $error("code 0x10 did not map to 1300 mV");

   a_external_zero: assert property (
      buck_ctrl_r.buck_one_external_adjust |=> buck_one_target_mv_r == 12'h000)
      else $error("external adjust still drives a register target");

endmodule

// ---- pgb_host_model.sv ----
// host-side model driving the register strobes of the config bank
// assumes the bench calls its tasks from one process only
module pgb_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata_r,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk);
   endtask

   // released lines show the inverse so a stale value never looks valid
   task automatic idle();
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, 1'b0, a, d);
      idle();
   endtask

   // key and protected write back to back, the tightest legal spacing
   task automatic uwr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, 1'b0, pgb_pkg::OFS_UNLOCK, pgb_pkg::UNLOCK_KEY);
      xfer(1'b1, 1'b0, a, d);
      idle();
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      xfer(1'b0, 1'b1, a, 8'h00);
      idle();
      @(negedge ref_clk);
      d = reg_rdata_r;
   endtask
endmodule

// ---- tb_power_good_and_buck1_config.sv ----
// self-checking bench for the power-good / buck-one configuration bank
// assumes short release delays of 5, 10, 20 and 40 cycles
module tb_power_good_and_buck1_config;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned DLY [4] = '{5, 10, 20, 40};
   localparam logic [7:0] CORNER [8] = '{8'hff, 8'h80, 8'h7f, 8'h02, 8'h30, 8'h36, 8'h6a, 8'h11};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic first_linear_good_status = 1'b0;
   logic second_linear_good_status = 1'b0;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata_r;
   logic power_good_output_o_r;
   logic power_good_output_oe_r;
   logic buck_one_external_adjust_r;
   logic [5:0] buck_one_voltage_code_r;
   logic [11:0] buck_one_target_mv_r;
   logic write_refused_r;
   int miscompares = 0;
   int n_compared = 0;
   int refusals = 0;
   int seed = 83162;

   always #20 ref_clk = ~ref_clk;

   // counted mid-cycle so the one-cycle pulse is never raced at its launching edge
   always @(negedge ref_clk)
      if (write_refused_r === 1'b1)
         refusals++;

   pgb_config_bank #(.DLY0_CYC(DLY[0]), .DLY1_CYC(DLY[1]), .DLY2_CYC(DLY[2]), .DLY3_CYC(DLY[3])) i_dut (
      .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
      .first_linear_good_status(first_linear_good_status),
      .second_linear_good_status(second_linear_good_status),
      .power_good_output_o_r(power_good_output_o_r), .power_good_output_oe_r(power_good_output_oe_r),
      .buck_one_external_adjust_r(buck_one_external_adjust_r),
      .buck_one_voltage_code_r(buck_one_voltage_code_r),
      .buck_one_target_mv_r(buck_one_target_mv_r), .write_refused_r(write_refused_r));

   pgb_host_model i_host (
      .ref_clk(ref_clk), .reg_rdata_r(reg_rdata_r), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // codes 0 and 1 extrapolate below the lowest listed step
   function automatic logic [11:0] exp_mv(input logic ext, input logic [5:0] c);
      int n;
      int v;
      n = int'(c);
      if (n <= 24)
         v = 900 + 25 * n;
      else if (n <= 52)
         v = 1500 + 50 * (n - 24);
      else
         v = 3000 + 100 * (n - 53);
      if (v > 3300)
         v = 3300;
      return ext ? 12'h000 : 12'(v);
   endfunction

   task automatic buck_case(input logic [7:0] d);
      logic [7:0] e;
      logic [7:0] got;
      e = {d[7], 1'b0, d[5:1], 1'b0};
      i_host.uwr(pgb_pkg::OFS_BUCK1_CTRL, d);
      i_host.rd(pgb_pkg::OFS_BUCK1_CTRL, got);
      check(12'(got), 12'(e), "buck register");
      check(12'(buck_one_voltage_code_r), 12'(e[5:0]), "code out");
      check(12'(buck_one_external_adjust_r), 12'(e[7]), "external select");
      check(buck_one_target_mv_r, exp_mv(e[7], e[5:0]), "target");
   endtask

   task automatic pg_case(input logic [1:0] dly, input logic m1, input logic m2, input logic s1, input logic s2);
      logic [7:0] got;
      int n;
      @(negedge ref_clk);
      first_linear_good_status = 1'b0;
      second_linear_good_status = 1'b0;
      i_host.uwr(pgb_pkg::OFS_PG_CTRL, {4'($random(seed)), m1, m2, dly});
      i_host.rd(pgb_pkg::OFS_PG_CTRL, got);
      check(12'(got), 12'({4'h0, m1, m2, dly}), "pg control");
      check(12'(power_good_output_oe_r), 12'h001, "pin held low");
      check(12'(power_good_output_o_r), 12'h000, "pin value low");
      first_linear_good_status = s1;
      second_linear_good_status = s2;
      n = 0;
      while (power_good_output_oe_r !== 1'b0 && n < 100)
      begin
         @(posedge ref_clk);
         n++;
         #1;
      end
      check(12'(n == DLY[dly] + 2 || n == DLY[dly] + 3), 12'h001, "release delay");
      check(12'(power_good_output_o_r), 12'h001, "pin released");
      i_host.rd(pgb_pkg::OFS_GOOD_STATUS, got);
      check(12'(got), 12'({6'h00, s1, s2}), "status");
      if (m1)
         second_linear_good_status = 1'b0;
      else
         first_linear_good_status = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check(12'(power_good_output_oe_r), 12'h001, "pin drop");
   endtask

   initial
   begin
      #(40 * 5000);
      miscompares++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end

   initial
   begin
      logic [7:0] d;
      int k;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      i_host.rd(pgb_pkg::OFS_PG_CTRL, d);
      check(12'(d), 12'h00c, "pg reset");
      i_host.rd(pgb_pkg::OFS_BUCK1_CTRL, d);
      check(12'(d), 12'h018, "buck reset");
      check(buck_one_target_mv_r, exp_mv(1'b0, 6'h18), "reset target");
      i_host.rd(8'h30, d);
      check(12'(d), 12'h000, "unmapped read");
      k = refusals;
      i_host.wr(pgb_pkg::OFS_PG_CTRL, 8'h00);
      // key, unmapped write, protected write back to back: the key is spent on the unmapped one
      i_host.xfer(1'b1, 1'b0, pgb_pkg::OFS_UNLOCK, pgb_pkg::UNLOCK_KEY);
      i_host.xfer(1'b1, 1'b0, 8'h30, 8'h55);
      i_host.xfer(1'b1, 1'b0, pgb_pkg::OFS_BUCK1_CTRL, 8'h80);
      i_host.idle();
      i_host.rd(pgb_pkg::OFS_PG_CTRL, d);
      check(12'(d), 12'h00c, "locked pg");
      i_host.rd(pgb_pkg::OFS_BUCK1_CTRL, d);
      check(12'(d), 12'h018, "spent unlock");
      check(12'(refusals - k), 12'h002, "refusal count");
      for (k = 0; k < $size(CORNER); k++)
         buck_case(CORNER[k]);
      for (k = 0; k < 24; k++)
         buck_case(8'($random(seed)));
      for (k = 0; k < 4; k++)
         pg_case(2'(k), 1'b0, 1'b0, 1'b1, 1'b1);
      pg_case(2'($random(seed)), 1'b1, 1'b0, 1'b0, 1'b1);
      pg_case(2'($random(seed)), 1'b0, 1'b1, 1'b1, 1'b0);
      @(negedge ref_clk);
      rst = 1'b1;
      @(negedge ref_clk);
      rst = 1'b0;
      i_host.rd(pgb_pkg::OFS_BUCK1_CTRL, d);
      check(12'(d), 12'h018, "second reset");
      stop_test();
   end
endmodule
